// ---- inc/smpg_params.svh ----
// Address map and field positions of the nibble register space.
// Assumes inclusion by the register bank only.
`ifndef SMPG_PARAMS_SVH
`define SMPG_PARAMS_SVH

`define SMPG_A_FLAGS      6'h00
`define SMPG_A_CE_DIR     6'h01
`define SMPG_A_PA_DIR     6'h02
`define SMPG_A_PA_VAL     6'h03
`define SMPG_A_PC_OUT     6'h04
`define SMPG_A_PB_DIR     6'h05
`define SMPG_A_PB_VAL     6'h06
`define SMPG_A_SCR1       6'h07
`define SMPG_A_SMP_XL     6'h08
`define SMPG_A_AUD_CTL    6'h09
`define SMPG_A_SMP_L      6'h0a
`define SMPG_A_SMP_H      6'h0b
`define SMPG_A_PE_VAL     6'h0e
`define SMPG_A_SCR2       6'h0f
`define SMPG_A_GAIN_TRIM  6'h10
`define SMPG_A_FMT_CTL    6'h11
`define SMPG_A_SPK_WAKE   6'h12
`define SMPG_A_UV_CTL     6'h13
`define SMPG_A_BIT_LIMIT  6'h0f
`define SMPG_A_RSVD_LO    6'h0c
`define SMPG_A_SRAM_BASE  6'h20
`define SMPG_SRAM_DEPTH   128
`define SMPG_ZERO4        4'h0
`define SMPG_BIT_IRQF     2
`define SMPG_BIT_CARRY    1
`define SMPG_BIT_ZERO     0
`define SMPG_BIT_GIE      1
`define SMPG_BIT_AUDEN    0
`define SMPG_BIT_FMT      0
`define SMPG_BIT_GAINON   1
`define SMPG_BIT_WKFLAG   3
`define SMPG_BIT_WKEN     2
`define SMPG_BIT_UVFLAG   1
`define SMPG_BIT_UVEN     0

`endif

// ---- inc/smpg_pkg.sv ----
// Types shared by the register bank and its users.
// Assumes the constants header is on the include path.
package smpg_pkg;
    typedef enum logic [1:0] {
        SMPG_W8  = 2'b00,
        SMPG_W10 = 2'b01,
        SMPG_W12 = 2'b10
    } smpg_width_t;

    typedef struct packed {
        logic [3:0]  flags;
        logic [3:0]  ce_dir;
        logic [3:0]  pa_dir;
        logic [3:0]  pa_out;
        logic [3:0]  pc_out;
        logic [3:0]  pb_dir;
        logic [3:0]  pb_out;
        logic [3:0]  scr1;
        logic [3:0]  smp_xl;
        logic [1:0]  aud_ctl;
        logic [3:0]  smp_l;
        logic [3:0]  smp_h;
        logic [3:0]  pe_out;
        logic [3:0]  scr2;
        logic [3:0]  gain_trim;
        logic [1:0]  fmt_ctl;
        logic [3:0]  spk_wake;
        logic        uv_en;
        logic [1:0]  page_select;
        logic [3:0]  rdata;
        logic [11:0] sample;
        logic [3:0]  pa_oe_n;
        logic [3:0]  pb_oe_n;
        logic [3:0]  pe_oe_n;
        logic [1:0]  gain_sel;
        logic [1:0]  trim;
    } smpg_state_t;
endpackage : smpg_pkg

// ---- logic/smpg_regbank.sv ----
// Nibble register space: common special function block plus paged user memory.
// Assumes a CPU core drives the documented load, store and bit-modify access
// ports on ref_clk_i; pin levels and sensor flags arrive from other domains.
`timescale 1ns/1ps
`include "smpg_params.svh"

module smpg_regbank (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic [5:0]  addr_i,
    input  wire logic        wr_i,
    input  wire logic [3:0]  wdata_i,
    input  wire logic        bit_set_i,
    input  wire logic        bit_clr_i,
    input  wire logic [1:0]  bit_sel_i,
    input  wire logic        indirect_i,
    input  wire logic        page_load_instr_i,
    input  wire logic [1:0]  page_i,
    input  wire logic        alu_flag_we_i,
    input  wire logic        carry_bit_i,
    input  wire logic        zero_bit_i,
    input  wire logic        audio_irq_set_i,
    input  wire logic        speaker_wake_i,
    input  wire logic        undervolt_i,
    input  wire logic [3:0]  pa_pin_i,
    input  wire logic [3:0]  pb_pin_i,
    input  wire logic [3:0]  pe_pin_i,
    input  wire logic        width_ten_option_i,
    input  wire logic        width_twelve_option_i,
    input  wire logic        bidir_ce_option_i,
    input  wire logic        port_e_bidir_option_i,
    input  wire logic        trim_build_option_i,
    input  wire logic        record_option_i,
    output logic [3:0]       rdata_o,
    output logic [3:0]       flags_o,
    output logic [3:0]       pa_out_o,
    output logic [3:0]       pa_oe_n_o,
    output logic [3:0]       pb_out_o,
    output logic [3:0]       pb_oe_n_o,
    output logic [3:0]       pc_out_o,
    output logic [3:0]       pe_out_o,
    output logic [3:0]       pe_oe_n_o,
    output logic [11:0]      sample_o,
    output logic             audio_out_enable_o,
    output logic             global_irq_enable_o,
    output logic             sample_format_sel_o,
    output logic             record_gain_on_o,
    output logic [1:0]       record_gain_sel_o,
    output logic [1:0]       freq_trim_o,
    output logic             speaker_wake_enable_o,
    output logic [1:0]       wake_sensitivity_o,
    output logic             speaker_wake_flag_o,
    output logic             undervolt_enable_o,
    output logic             undervolt_flag_o
);

    smpg_pkg::smpg_state_t s_q, s_d;

    // Three-stage synchronisers; a change counts once stages two and three agree.
    logic [2:0] wk_sync_q, uv_sync_q;
    logic [3:0] pa_s1_q, pa_s2_q, pa_s3_q, pa_lv_q;
    logic [3:0] pb_s1_q, pb_s2_q, pb_s3_q, pb_lv_q;
    logic [3:0] pe_s1_q, pe_s2_q, pe_s3_q, pe_lv_q;
    logic       wk_lv_q, wk_prev_q, uv_lv_q;

    // User memory has no reset; its content is undefined until written.
    logic [3:0] sram_q [`SMPG_SRAM_DEPTH];

    function automatic logic [3:0] bit_mod(input logic [3:0] v, input logic [1:0] sel,
                                           input logic set, input logic clr);
        logic [3:0] r;
        r = v;
        if (set) begin
            r[sel] = 1'b1;
        end else if (clr) begin
            r[sel] = 1'b0;
        end
        return r;
    endfunction : bit_mod

    logic        in_sram;
    logic [6:0]  sram_idx;
    logic        bm_ok;
    logic        bm;
    logic [3:0]  cur;
    logic [3:0]  nv;
    logic        wr_any;
    logic        wake_evt;
    smpg_pkg::smpg_width_t wmode;

    assign in_sram  = addr_i >= `SMPG_A_SRAM_BASE;
    assign sram_idx = {s_q.page_select, addr_i[4:0]};
    assign bm       = bit_set_i | bit_clr_i;
    assign bm_ok    = indirect_i || (addr_i <= `SMPG_A_BIT_LIMIT);
    assign wr_any   = wr_i | (bm & bm_ok);
    assign wake_evt = wk_lv_q & ~wk_prev_q;

    always_comb begin
        if (width_twelve_option_i) begin
            wmode = smpg_pkg::SMPG_W12;
        end else if (width_ten_option_i) begin
            wmode = smpg_pkg::SMPG_W10;
        end else begin
            wmode = smpg_pkg::SMPG_W8;
        end
    end

    always_comb begin
        s_d = s_q;
        // Read-modify-write sees the stored latch, so bit writes on ports keep other bits.
        unique case (addr_i)
            `SMPG_A_FLAGS:     cur = s_q.flags;
            `SMPG_A_CE_DIR:    cur = s_q.ce_dir;
            `SMPG_A_PA_DIR:    cur = s_q.pa_dir;
            `SMPG_A_PA_VAL:    cur = s_q.pa_out;
            `SMPG_A_PC_OUT:    cur = s_q.pc_out;
            `SMPG_A_PB_DIR:    cur = s_q.pb_dir;
            `SMPG_A_PB_VAL:    cur = s_q.pb_out;
            `SMPG_A_SCR1:      cur = s_q.scr1;
            `SMPG_A_AUD_CTL:   cur = {2'b00, s_q.aud_ctl};
            `SMPG_A_PE_VAL:    cur = s_q.pe_out;
            `SMPG_A_SCR2:      cur = s_q.scr2;
            `SMPG_A_GAIN_TRIM: cur = s_q.gain_trim;
            `SMPG_A_FMT_CTL:   cur = {2'b00, s_q.fmt_ctl};
            `SMPG_A_SPK_WAKE:  cur = s_q.spk_wake;
            `SMPG_A_UV_CTL:    cur = {2'b00, uv_lv_q, s_q.uv_en};
            default:           cur = `SMPG_ZERO4;
        endcase
        nv = wr_i ? wdata_i : bit_mod(cur, bit_sel_i, bit_set_i, bit_clr_i);

        if (page_load_instr_i) begin
            s_d.page_select = page_i;
        end
        if (alu_flag_we_i) begin
            s_d.flags[`SMPG_BIT_CARRY] = carry_bit_i;
            s_d.flags[`SMPG_BIT_ZERO]  = zero_bit_i;
        end
        if (wr_any && !in_sram) begin
            unique case (addr_i)
                `SMPG_A_FLAGS:     s_d.flags = {1'b0, nv[2:0]};
                `SMPG_A_CE_DIR:    s_d.ce_dir = nv;
                `SMPG_A_PA_DIR:    s_d.pa_dir = nv;
                `SMPG_A_PA_VAL:    s_d.pa_out = nv;
                `SMPG_A_PC_OUT:    s_d.pc_out = nv;
                `SMPG_A_PB_DIR:    s_d.pb_dir = nv;
                `SMPG_A_PB_VAL:    s_d.pb_out = nv;
                `SMPG_A_SCR1:      s_d.scr1 = nv;
                `SMPG_A_SMP_XL:    s_d.smp_xl = nv;
                `SMPG_A_AUD_CTL:   s_d.aud_ctl = nv[1:0];
                `SMPG_A_SMP_L:     s_d.smp_l = nv;
                `SMPG_A_SMP_H:     s_d.smp_h = nv;
                `SMPG_A_PE_VAL:    s_d.pe_out = nv;
                `SMPG_A_SCR2:      s_d.scr2 = nv;
                `SMPG_A_GAIN_TRIM: s_d.gain_trim = nv;
                `SMPG_A_FMT_CTL:   s_d.fmt_ctl = nv[1:0];
                `SMPG_A_SPK_WAKE:  s_d.spk_wake = nv;
                `SMPG_A_UV_CTL:    s_d.uv_en = nv[`SMPG_BIT_UVEN];
                default:           ;
            endcase
        end
        // Hardware sets win over a software clear in the same cycle.
        if (audio_irq_set_i) begin
            s_d.flags[`SMPG_BIT_IRQF] = 1'b1;
        end
        if (wake_evt && s_q.spk_wake[`SMPG_BIT_WKEN]) begin
            s_d.spk_wake[`SMPG_BIT_WKFLAG] = 1'b1;
        end

        // Read data; write-only and reserved nibbles read zero here.
        if (in_sram) begin
            s_d.rdata = sram_q[sram_idx];
        end else begin
            unique case (addr_i)
                `SMPG_A_PA_VAL: s_d.rdata = pa_lv_q;
                `SMPG_A_PB_VAL: s_d.rdata = pb_lv_q;
                `SMPG_A_PE_VAL: s_d.rdata = pe_lv_q;
                default:        s_d.rdata = cur;
            endcase
        end

        unique case (wmode)
            smpg_pkg::SMPG_W12: s_d.sample = {s_q.smp_h, s_q.smp_l, s_q.smp_xl};
            smpg_pkg::SMPG_W10: s_d.sample = {2'b00, s_q.smp_h, s_q.smp_l,
                                              s_q.smp_xl[3:2]};
            default:            s_d.sample = {4'h0, s_q.smp_h, s_q.smp_l};
        endcase

        s_d.pa_oe_n = ~s_q.pa_dir;
        s_d.pb_oe_n = ~s_q.pb_dir;
        s_d.pe_oe_n = (bidir_ce_option_i || port_e_bidir_option_i) ?
                      ~s_q.ce_dir : 4'hf;
        // Option gates are registered here so that these outputs leave from flops too.
        s_d.gain_sel = (record_option_i && s_d.fmt_ctl[`SMPG_BIT_GAINON]) ?
                       s_d.gain_trim[3:2] : 2'h0;
        s_d.trim     = trim_build_option_i ? s_d.gain_trim[1:0] : 2'h0;
    end

    always_ff @(posedge ref_clk_i) begin
        if (wr_any && in_sram) begin
            sram_q[sram_idx] <= nv;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
            {wk_sync_q, uv_sync_q, wk_lv_q, wk_prev_q, uv_lv_q} <= '0;
            {pa_s1_q, pa_s2_q, pa_s3_q, pa_lv_q} <= '0;
            {pb_s1_q, pb_s2_q, pb_s3_q, pb_lv_q} <= '0;
            {pe_s1_q, pe_s2_q, pe_s3_q, pe_lv_q} <= '0;
        end else begin
            s_q <= s_d;
            wk_sync_q <= {wk_sync_q[1:0], speaker_wake_i};
            uv_sync_q <= {uv_sync_q[1:0], undervolt_i};
            pa_s1_q <= pa_pin_i;
            pa_s2_q <= pa_s1_q;
            pa_s3_q <= pa_s2_q;
            pb_s1_q <= pb_pin_i;
            pb_s2_q <= pb_s1_q;
            pb_s3_q <= pb_s2_q;
            pe_s1_q <= pe_pin_i;
            pe_s2_q <= pe_s1_q;
            pe_s3_q <= pe_s2_q;
            for (int i = 0; i < 4; i++) begin
                if (pa_s2_q[i] == pa_s3_q[i]) pa_lv_q[i] <= pa_s3_q[i];
                if (pb_s2_q[i] == pb_s3_q[i]) pb_lv_q[i] <= pb_s3_q[i];
                if (pe_s2_q[i] == pe_s3_q[i]) pe_lv_q[i] <= pe_s3_q[i];
            end
            if (wk_sync_q[1] == wk_sync_q[2]) wk_lv_q <= wk_sync_q[2];
            if (uv_sync_q[1] == uv_sync_q[2]) uv_lv_q <= uv_sync_q[2] & s_q.uv_en;
            wk_prev_q <= wk_lv_q;
        end
    end

    assign rdata_o               = s_q.rdata;
    assign flags_o               = s_q.flags;
    assign pa_out_o              = s_q.pa_out;
    assign pa_oe_n_o             = s_q.pa_oe_n;
    assign pb_out_o              = s_q.pb_out;
    assign pb_oe_n_o             = s_q.pb_oe_n;
    assign pc_out_o              = s_q.pc_out;
    assign pe_out_o              = s_q.pe_out;
    assign pe_oe_n_o             = s_q.pe_oe_n;
    assign sample_o              = s_q.sample;
    assign audio_out_enable_o    = s_q.aud_ctl[`SMPG_BIT_AUDEN];
    assign global_irq_enable_o   = s_q.aud_ctl[`SMPG_BIT_GIE];
    assign sample_format_sel_o   = s_q.fmt_ctl[`SMPG_BIT_FMT];
    assign record_gain_on_o      = s_q.fmt_ctl[`SMPG_BIT_GAINON];
    assign record_gain_sel_o     = s_q.gain_sel;
    assign freq_trim_o           = s_q.trim;
    assign speaker_wake_enable_o = s_q.spk_wake[`SMPG_BIT_WKEN];
    assign wake_sensitivity_o    = s_q.spk_wake[1:0];
    assign speaker_wake_flag_o   = s_q.spk_wake[`SMPG_BIT_WKFLAG];
    assign undervolt_enable_o    = s_q.uv_en;
    assign undervolt_flag_o      = uv_lv_q;

    sequence wake_seen;
        wake_evt && s_q.spk_wake[`SMPG_BIT_WKEN];
    endsequence

    sequence high_bit_op;
        bm && !wr_i && !indirect_i && addr_i == `SMPG_A_GAIN_TRIM;
    endsequence

    sequence sram_store;
        wr_i && !page_load_instr_i && addr_i >= `SMPG_A_SRAM_BASE;
    endsequence

    sequence alu_update;
        alu_flag_we_i && !(wr_any && addr_i == `SMPG_A_FLAGS);
    endsequence

    sequence page_load_seen;
        page_load_instr_i;
    endsequence

    AST_WAKE_STICKY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wake_seen |=> speaker_wake_flag_o)
        else $error("wake flag not set");
    AST_IRQ_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        audio_irq_set_i |=> flags_o[`SMPG_BIT_IRQF])
        else $error("irq flag not set");
    AST_BIT_LIMIT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        high_bit_op |=> $stable(s_q.gain_trim))
        else $error("bit op reached high register");
    AST_PA_DIR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_i && addr_i == `SMPG_A_PA_DIR) |=> ##1 pa_oe_n_o == ~$past(wdata_i, 2))
        else $error("port a enable mismatch");
    AST_PC_OUT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_i && addr_i == `SMPG_A_PC_OUT) |=> pc_out_o == $past(wdata_i))
        else $error("port c latch mismatch");
    AST_SIGN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_i && addr_i == `SMPG_A_SMP_H && width_twelve_option_i)
        |=> ##1 sample_o[11] == $past(wdata_i[3], 2))
        else $error("sign bit misplaced");
    AST_RSVD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_i && addr_i == `SMPG_A_RSVD_LO) |=> $stable(s_q.scr2))
        else $error("reserved write had effect");
    AST_AUD_EN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_i && addr_i == `SMPG_A_AUD_CTL) |=> audio_out_enable_o == $past(wdata_i[0]))
        else $error("audio enable mismatch");
    AST_PAGE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        page_load_seen |=> s_q.page_select == $past(page_i))
        else $error("page select not loaded");
    AST_SRAM_WR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sram_store ##1 addr_i == $past(addr_i) |=> rdata_o == $past(wdata_i, 2))
        else $error("user memory readback mismatch");
    AST_CARRY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        alu_update |=> flags_o[1:0] == $past({carry_bit_i, zero_bit_i}))
        else $error("carry or zero flag mismatch");
    AST_PB_DIR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_i && addr_i == `SMPG_A_PB_DIR) |=> ##1 pb_oe_n_o == ~$past(wdata_i, 2))
        else $error("port b enable mismatch");
    AST_CE_DIR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_i && addr_i == `SMPG_A_CE_DIR && bidir_ce_option_i)
        |=> ##1 pe_oe_n_o == ~$past(wdata_i, 2))
        else $error("port ce enable mismatch");
    AST_PA_LATCH: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_i && addr_i == `SMPG_A_PA_VAL) |=> pa_out_o == $past(wdata_i))
        else $error("port a latch mismatch");
    AST_PB_LATCH: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_i && addr_i == `SMPG_A_PB_VAL) |=> pb_out_o == $past(wdata_i))
        else $error("port b latch mismatch");
    AST_PE_LATCH: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_i && addr_i == `SMPG_A_PE_VAL) |=> pe_out_o == $past(wdata_i))
        else $error("port e latch mismatch");
    AST_SCR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_i && addr_i == `SMPG_A_SCR2) |=> s_q.scr2 == $past(wdata_i))
        else $error("scratch nibble mismatch");
    AST_SAMPLE_LOW: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_i && addr_i == `SMPG_A_SMP_XL && width_twelve_option_i)
        |=> ##1 sample_o[3:0] == $past(wdata_i, 2))
        else $error("low sample nibble misplaced");
    AST_GIE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_i && addr_i == `SMPG_A_AUD_CTL) |=> global_irq_enable_o == $past(wdata_i[1]))
        else $error("global irq enable mismatch");
    AST_FMT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_i && addr_i == `SMPG_A_FMT_CTL)
        |=> {record_gain_on_o, sample_format_sel_o} == $past(wdata_i[1:0]))
        else $error("format control mismatch");
    AST_WAKE_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (speaker_wake_flag_o && !(wr_any && addr_i == `SMPG_A_SPK_WAKE))
        |=> speaker_wake_flag_o)
        else $error("wake flag dropped without a clear");
    AST_SENS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_i && addr_i == `SMPG_A_SPK_WAKE) |=> wake_sensitivity_o == $past(wdata_i[1:0]))
        else $error("wake sensitivity mismatch");
    AST_TRIM_GATE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !trim_build_option_i |=> freq_trim_o == 2'h0)
        else $error("trim applied without its option");
    AST_GAIN_GATE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !record_option_i |=> record_gain_sel_o == 2'h0)
        else $error("gain select applied without record option");
    AST_UV_EN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_i && addr_i == `SMPG_A_UV_CTL) |=> undervolt_enable_o == $past(wdata_i[0]))
        else $error("undervolt enable mismatch");

endmodule : smpg_regbank

// ---- bench/smpg_regbank_tb_top.sv ----
// Self-checking bench for the nibble register bank and its paged user memory.
// Assumes the package and constants header are compiled or on the include path.
`timescale 1ns/1ps

`define CK(nm, ev, gv) begin \
    compares++; \
    if ((gv) !== (ev)) begin \
        error_cnt++; \
        $display("wrong value %s exp %0h got %0h", nm, ev, gv); \
    end \
end

module smpg_regbank_tb_top;
    logic        ref_clk_i, rst_i, wr_i, bit_set_i, bit_clr_i, indirect_i;
    logic        page_load_instr_i, alu_flag_we_i, carry_bit_i, zero_bit_i;
    logic        audio_irq_set_i, speaker_wake_i, undervolt_i;
    logic        width_ten_option_i, width_twelve_option_i, bidir_ce_option_i;
    logic        port_e_bidir_option_i, trim_build_option_i, record_option_i;
    logic [5:0]  addr_i;
    logic [3:0]  wdata_i, pa_pin_i, pb_pin_i, pe_pin_i;
    logic [1:0]  bit_sel_i, page_i;
    logic [3:0]  rdata_o, flags_o, pa_out_o, pa_oe_n_o, pb_out_o, pb_oe_n_o;
    logic [3:0]  pc_out_o, pe_out_o, pe_oe_n_o;
    logic [11:0] sample_o;
    logic        audio_out_enable_o, global_irq_enable_o, sample_format_sel_o;
    logic        record_gain_on_o, speaker_wake_enable_o, speaker_wake_flag_o;
    logic        undervolt_enable_o, undervolt_flag_o;
    logic [1:0]  record_gain_sel_o, freq_trim_o, wake_sensitivity_o;
    int          error_cnt, compares, cyc;

    smpg_regbank dut_u (.*);

    always #25 ref_clk_i = ~ref_clk_i;

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : tick

    task automatic wr(input logic [5:0] a, input logic [3:0] d);
        addr_i = a;
        wdata_i = d;
        wr_i = 1'b1;
        tick(1);
        wr_i = 1'b0;
    endtask : wr

    task automatic rchk(input logic [5:0] a, input logic [3:0] e);
        addr_i = a;
        tick(2);
        `CK("rdata", e, rdata_o)
    endtask : rchk

    task automatic bop(input logic s, input logic [5:0] a, input logic [1:0] b,
                       input logic ind);
        addr_i = a;
        bit_sel_i = b;
        indirect_i = ind;
        bit_set_i = s;
        bit_clr_i = !s;
        tick(1);
        bit_set_i = 1'b0;
        bit_clr_i = 1'b0;
        indirect_i = 1'b0;
    endtask : bop

    task automatic pg(input logic [1:0] p);
        page_i = p;
        page_load_instr_i = 1'b1;
        tick(1);
        page_load_instr_i = 1'b0;
    endtask : pg

    task automatic t_reset();
        logic [5:0] z[8] = '{6'h01, 6'h02, 6'h04, 6'h05, 6'h10, 6'h11, 6'h12, 6'h13};
        `CK("flags_hi", 2'b00, flags_o[3:2])
        `CK("pa_oe_n", 4'hf, pa_oe_n_o)
        `CK("pb_oe_n", 4'hf, pb_oe_n_o)
        foreach (z[i]) rchk(z[i], 4'h0);
    endtask : t_reset

    task automatic t_dir();
        wr(6'h02, 4'h5);
        wr(6'h05, 4'h3);
        wr(6'h01, 4'h6);
        tick(2);
        `CK("pa_oe_n", 4'ha, pa_oe_n_o)
        `CK("pb_oe_n", 4'hc, pb_oe_n_o)
        `CK("pe_oe_n", 4'h9, pe_oe_n_o)
        rchk(6'h02, 4'h5);
        bidir_ce_option_i = 1'b0;
        port_e_bidir_option_i = 1'b0;
        tick(2);
        `CK("pe_oe_n", 4'hf, pe_oe_n_o)
        bidir_ce_option_i = 1'b1;
        port_e_bidir_option_i = 1'b1;
        tick(2);
    endtask : t_dir

    task automatic t_port();
        wr(6'h03, 4'h9);
        wr(6'h06, 4'hc);
        wr(6'h0e, 4'h3);
        wr(6'h04, 4'h7);
        tick(2);
        `CK("pa_out", 4'h9, pa_out_o)
        `CK("pb_out", 4'hc, pb_out_o)
        `CK("pe_out", 4'h3, pe_out_o)
        `CK("pc_out", 4'h7, pc_out_o)
        // Pins pass a three-stage synchroniser, so pin reads wait six cycles.
        pa_pin_i = 4'h6;
        pb_pin_i = 4'ha;
        pe_pin_i = 4'h5;
        tick(6);
        rchk(6'h03, 4'h6);
        rchk(6'h06, 4'ha);
        rchk(6'h0e, 4'h5);
    endtask : t_port

    task automatic t_scr();
        wr(6'h07, 4'ha);
        wr(6'h0f, 4'h5);
        wr(6'h0c, 4'hf);
        wr(6'h0d, 4'hf);
        rchk(6'h07, 4'ha);
        rchk(6'h0f, 4'h5);
        rchk(6'h0c, 4'h0);
        rchk(6'h0d, 4'h0);
    endtask : t_scr

    task automatic t_bit();
        bop(1'b1, 6'h07, 2'd0, 1'b0);
        rchk(6'h07, 4'hb);
        bop(1'b0, 6'h07, 2'd3, 1'b0);
        rchk(6'h07, 4'h3);
        bop(1'b1, 6'h10, 2'd2, 1'b0);
        rchk(6'h10, 4'h0);
        bop(1'b1, 6'h10, 2'd2, 1'b1);
        rchk(6'h10, 4'h4);
    endtask : t_bit

    task automatic t_flags();
        carry_bit_i = 1'b1;
        zero_bit_i = 1'b1;
        alu_flag_we_i = 1'b1;
        tick(1);
        alu_flag_we_i = 1'b0;
        audio_irq_set_i = 1'b1;
        tick(1);
        audio_irq_set_i = 1'b0;
        tick(2);
        `CK("flags", 3'b111, flags_o[2:0])
        bop(1'b0, 6'h00, 2'd2, 1'b0);
        tick(1);
        `CK("irq_flag", 1'b0, flags_o[2])
    endtask : t_flags

    task automatic t_sample();
        wr(6'h08, 4'hd);
        wr(6'h0a, 4'h6);
        wr(6'h0b, 4'h9);
        // Let the twelve-bit sample settle before the width option moves.
        tick(2);
        width_twelve_option_i = 1'b0;
        tick(3);
        `CK("sample8", 8'h96, sample_o[7:0])
        width_ten_option_i = 1'b1;
        tick(3);
        `CK("sample10", 10'h25b, sample_o[9:0])
        width_ten_option_i = 1'b0;
        width_twelve_option_i = 1'b1;
        tick(3);
        `CK("sample12", 12'h96d, sample_o)
        wr(6'h0b, 4'h1);
        tick(3);
        `CK("sign", 1'b0, sample_o[11])
        rchk(6'h08, 4'h0);
    endtask : t_sample

    task automatic t_ctl();
        wr(6'h09, 4'h3);
        tick(2);
        `CK("aud_ctl", 2'b11, {global_irq_enable_o, audio_out_enable_o})
        rchk(6'h09, 4'h3);
        wr(6'h09, 4'h2);
        tick(2);
        `CK("aud_ctl", 2'b10, {global_irq_enable_o, audio_out_enable_o})
        wr(6'h11, 4'h1);
        tick(2);
        `CK("fmt_ctl", 2'b01, {record_gain_on_o, sample_format_sel_o})
        wr(6'h11, 4'h2);
        tick(2);
        `CK("fmt_ctl", 2'b10, {record_gain_on_o, sample_format_sel_o})
        for (int i = 0; i < 4; i++) begin
            wr(6'h10, {2'(i), 2'(3 - i)});
            tick(2);
            `CK("gain_trim", {2'(i), 2'(3 - i)}, {record_gain_sel_o, freq_trim_o})
        end
        trim_build_option_i = 1'b0;
        record_option_i = 1'b0;
        tick(2);
        `CK("gain_trim_off", 4'h0, {record_gain_sel_o, freq_trim_o})
        trim_build_option_i = 1'b1;
        record_option_i = 1'b1;
        tick(2);
    endtask : t_ctl

    task automatic t_wake();
        for (int s = 0; s < 4; s++) begin
            wr(6'h12, {2'b01, 2'(s)});
            tick(2);
            `CK("wake", {1'b1, 2'(s)}, {speaker_wake_enable_o, wake_sensitivity_o})
        end
        speaker_wake_i = 1'b1;
        tick(6);
        speaker_wake_i = 1'b0;
        tick(4);
        `CK("wake_flag", 1'b1, speaker_wake_flag_o)
        rchk(6'h12, 4'hf);
        wr(6'h12, 4'h4);
        tick(2);
        `CK("wake_flag", 1'b0, speaker_wake_flag_o)
    endtask : t_wake

    task automatic t_uv();
        wr(6'h13, 4'h1);
        undervolt_i = 1'b1;
        tick(6);
        `CK("uv_flag", 1'b1, undervolt_flag_o)
        rchk(6'h13, 4'h3);
        wr(6'h13, 4'h2);
        undervolt_i = 1'b0;
        tick(2);
        `CK("uv_en", 1'b0, undervolt_enable_o)
    endtask : t_uv

    task automatic t_sram();
        for (int p = 0; p < 4; p++) begin
            pg(2'(p));
            wr(6'h20, 4'(p + 1));
            wr(6'h3f, 4'(p + 8));
        end
        for (int p = 0; p < 4; p++) begin
            pg(2'(p));
            rchk(6'h20, 4'(p + 1));
            rchk(6'h3f, 4'(p + 8));
            rchk(6'h07, 4'h3);
        end
    endtask : t_sram

    task automatic test_done();
        $display("mismatches %0d of %0d compares", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end

    initial begin
        {ref_clk_i, wr_i, bit_set_i, bit_clr_i, indirect_i, page_load_instr_i} = '0;
        {alu_flag_we_i, carry_bit_i, zero_bit_i, audio_irq_set_i} = '0;
        {speaker_wake_i, undervolt_i, width_ten_option_i} = '0;
        {width_twelve_option_i, bidir_ce_option_i, port_e_bidir_option_i} = '1;
        {trim_build_option_i, record_option_i} = '1;
        {addr_i, wdata_i, pa_pin_i, pb_pin_i, pe_pin_i, bit_sel_i, page_i} = '0;
        rst_i = 1'b1;
        tick(20);
        rst_i = 1'b0;
        tick(2);
        t_reset();
        t_dir();
        t_port();
        t_scr();
        t_bit();
        t_flags();
        t_sample();
        t_ctl();
        t_wake();
        t_uv();
        t_sram();
        test_done();
    end
endmodule : smpg_regbank_tb_top
